// File: rtl/sml_aux_clk.sv
// Auxiliary clock generator, frequency-locked to pclk by a phase accumulator.
// Assumes pclk at 200 MHz; the 125 MHz code aliases to 75 MHz, with one pclk period of edge jitter.
`timescale 1ns/100ps
module sml_aux_clk (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic enable,
  input wire logic [1:0] freq,
  // Clock out
  output logic clk_o
);
  import sml_pkg::*;

  logic [SML_ACC_W-1:0] acc_q;
  logic [SML_ACC_W-1:0] inc;
  logic run;

  // ==========================================================================
  // Rate select
  always_comb
  begin
    run = enable;
    case (freq)
      SML_FRQ_25: inc = SML_INC_25;
      SML_FRQ_50: inc = SML_INC_50;
      SML_FRQ_125: inc = SML_INC_125;
      default:
      begin
        inc = '0;
        run = 1'b0;
      end
    endcase
  end

  // ==========================================================================
  // Accumulator and output; a stopped clock sits low.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      acc_q <= '0;
      clk_o <= 1'b0;
    end
    else
    begin
      acc_q <= run ? acc_q + inc : '0;
      clk_o <= run & acc_q[SML_ACC_W-1];
    end
  end

endmodule

// File: rtl/sml_pkg.sv
// Package for the strap mode latch: register map, field positions, codes and carriers.
// Assumes a 200 MHz APB clock and straps that are stable while the chip reset is held.
package sml_pkg;

  // ==========================================================================
  // Register map
  localparam logic [7:0] SML_OFF_STRAPS = 8'h00;
  localparam logic [7:0] SML_OFF_AUXCLK = 8'h04;
  localparam logic [7:0] SML_OFF_LINK = 8'h08;
  localparam logic [7:0] SML_OFF_MACIF = 8'h0C;
  localparam logic [7:0] SML_OFF_DELAY = 8'h10;
  localparam logic [7:0] SML_OFF_POWER = 8'h14;
  localparam logic [7:0] SML_OFF_XOVER = 8'h18;
  localparam logic [7:0] SML_OFF_ADDR = 8'h1C;

  // ==========================================================================
  // Field positions
  localparam int SML_BIT_AUX_EN = 15;
  localparam int SML_BIT_AUX_FRQ = 13;
  localparam int SML_BIT_SPD_LSB = 13;
  localparam int SML_BIT_ANEG = 12;
  localparam int SML_BIT_DUPLEX = 8;
  localparam int SML_BIT_SPD_MSB = 6;
  localparam int SML_BIT_MACIF = 11;
  localparam int SML_BIT_RX_DLY = 4;
  localparam int SML_BIT_TX_DLY = 0;
  localparam int SML_BIT_PWR = 6;
  localparam int SML_BIT_XOVER = 2;
  localparam int SML_BIT_UNMGD = 5;
  localparam int SML_BIT_LOADED = 31;

  // ==========================================================================
  // Codes and reset values
  localparam logic [1:0] SML_FRQ_25 = 2'h0;
  localparam logic [1:0] SML_FRQ_50 = 2'h1;
  localparam logic [1:0] SML_FRQ_125 = 2'h2;
  localparam logic [1:0] SML_MAC_MII = 2'h0;
  localparam logic [1:0] SML_MAC_RMII = 2'h1;
  localparam logic [1:0] SML_MAC_RGMII = 2'h2;
  localparam logic [1:0] SML_XOVER_AUTO = 2'h0;
  localparam logic [2:0] SML_DLY_RST = 3'h0;
  localparam logic [4:0] SML_ADDR_RST = 5'h00;

  // ==========================================================================
  // Auxiliary clock synthesis: a 4-bit phase accumulator at 200 MHz.
  localparam int SML_ACC_W = 4;
  localparam logic [3:0] SML_INC_25 = 4'h2;
  localparam logic [3:0] SML_INC_50 = 4'h4;
  localparam logic [3:0] SML_INC_125 = 4'hA;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic aux_en;
    logic mgmt_sel;
    logic sig_a;
    logic sig_b;
    logic sig_c;
    logic sig_d;
    logic sig_e;
    logic mac_type;
    logic addr_low;
    logic addr_high;
    logic freq_low;
    logic freq_high;
  } sml_straps_s;

  typedef struct packed {
    logic [4:0] mgmt_addr;
    logic unmanaged;
    logic [1:0] mac_if;
    logic aneg_en;
    logic speed_lsb;
    logic speed_msb;
    logic duplex;
    logic [1:0] xover;
    logic [2:0] rx_dly;
    logic [2:0] tx_dly;
    logic power_save;
    logic aux_en;
    logic [1:0] aux_freq;
  } sml_cfg_s;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } sml_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } sml_apb_rsp_s;

endpackage

// File: rtl/sml_sync.sv
// Two-flop synchroniser for a group of levels from outside the clock domain.
// Assumes each bit is a slow level; no word coherence across bits is promised.
`timescale 1ns/100ps
module sml_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Levels
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);

  logic [W-1:0] meta_q;

  // ==========================================================================
  // Synchroniser
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_q <= '0;
      sync_o <= '0;
    end
    else
    begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end

endmodule

// File: rtl/sml_top.sv
// Strap mode latch: captures board straps at chip reset release and holds config registers.
// Assumes straps are set by resistors only while chip_reset_low is low, and an APB master.
//
// Summary of operation
// - Strap pins are inputs during chip reset; levels are latched at its release.
// - Aux clock strap 0 disables the clock and drives low; 1 enables it.
// - Aux clock enable is a read/write register bit overriding the strap after reset.
// - Aux clock frequency is a two-bit field, locked to the reference clock.
// - Frequency codes: 00 is 25 MHz, 01 is 50, 10 is the 125 setting (75 MHz out), 11 reserved.
// - Frequency straps load the field default, low pin to bit 0, high to bit 1.
// - Software may rewrite the frequency field to any allowed setting after reset.
// - Management strap 0 is managed mode; straps A to E form the address.
// - In managed mode straps A to E change no operating configuration.
// - Management strap 1 is unmanaged mode; A to E select default configuration.
// - Speed, autoneg, duplex, MAC interface and delay defaults follow straps; crossover resets to auto.
// - In unmanaged mode the power saving bit resets to 1.
// - In unmanaged mode A and B load both delay fields as 000, 010, 100, 110.
// - C low gives autoneg; C,D 10 forces 100 half, 11 forces 10 half.
// - In unmanaged mode strap E 0 keeps the MAC type strap choice, 1 selects RMII.
// - Inconsistent strap sets are not rejected; boards avoid RMII with autoneg.
// - Unmanaged address takes bits 0 and 1 from address straps, upper bits zero.
// - The MAC type strap selects RGMII at 0 and MII at 1.
// - Unmanaged with E at 1 uses RMII whatever the MAC type strap says.
`timescale 1ns/100ps
module sml_top (
  // APB clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire sml_pkg::sml_apb_req_s apb_req,
  output sml_pkg::sml_apb_rsp_s apb_rsp,
  // Chip reset pin and strap levels
  input wire logic chip_reset_low,
  input wire sml_pkg::sml_straps_s strap_pins,
  // Strap pin release: high while the pins must be left as inputs
  output logic strap_hold,
  // Auxiliary clock pin, output enable active low
  output logic aux_clock_output_o,
  output logic aux_clock_output_oe_n,
  // Configuration to the rest of the device
  output sml_pkg::sml_cfg_s cfg
);
  import sml_pkg::*;

  // ==========================================================================
  // Declarations
  logic chip_run;
  sml_straps_s straps_sync;
  logic chip_run_prev_q;
  logic release_pulse;
  sml_straps_s straps_q;
  logic loaded_q;
  sml_cfg_s cfg_q;
  sml_cfg_s cfg_d;
  sml_cfg_s cfg_dflt;
  logic aux_clk;
  logic acc_phase;
  logic wr_phase;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata_d;
  logic hit_d;
  logic pready_q;
  logic [31:0] prdata_q;
  logic pslverr_q;

  // ==========================================================================
  // Crossing of the chip reset pin and the strap pins
  // Both pass two flops; nothing reads the first stage.
  sml_sync #(
    .W(1)
  ) u_rst_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_i(chip_reset_low),
    .sync_o(chip_run)
  );

  sml_sync #(
    .W($bits(sml_straps_s))
  ) u_strap_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_i(strap_pins),
    .sync_o(straps_sync)
  );

  // ==========================================================================
  // Release detection
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      chip_run_prev_q <= 1'b0;
    end
    else
    begin
      chip_run_prev_q <= chip_run;
    end
  end

  // The straps have been stable through reset, so the synchronised copy seen at the
  // release edge is the level the board set.
  assign release_pulse = chip_run & ~chip_run_prev_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      straps_q <= '0;
      loaded_q <= 1'b0;
    end
    else if (!chip_run)
    begin
      loaded_q <= 1'b0;
    end
    else if (release_pulse)
    begin
      straps_q <= straps_sync;
      loaded_q <= 1'b1;
    end
  end

  // Pins stay held as inputs from power-up until the first capture after chip reset.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      strap_hold <= 1'b1;
    end
    else
    begin
      strap_hold <= ~chip_run | release_pulse;
    end
  end

  // ==========================================================================
  // Strap decode into register defaults
  // No combination is refused; an RMII board that straps autoneg simply gets it.
  always_comb
  begin
    cfg_dflt = '0;
    cfg_dflt.aux_en = straps_sync.aux_en;
    cfg_dflt.aux_freq = {straps_sync.freq_high, straps_sync.freq_low};
    cfg_dflt.unmanaged = straps_sync.mgmt_sel;
    cfg_dflt.xover = SML_XOVER_AUTO;
    cfg_dflt.aneg_en = 1'b1;
    cfg_dflt.speed_lsb = 1'b1;
    cfg_dflt.speed_msb = 1'b0;
    cfg_dflt.duplex = 1'b1;
    cfg_dflt.rx_dly = SML_DLY_RST;
    cfg_dflt.tx_dly = SML_DLY_RST;
    cfg_dflt.power_save = 1'b0;
    cfg_dflt.mac_if = straps_sync.mac_type ? SML_MAC_MII : SML_MAC_RGMII;
    if (!straps_sync.mgmt_sel)
    begin
      // Managed: A to E are the address and nothing else.
      cfg_dflt.mgmt_addr = {straps_sync.sig_e, straps_sync.sig_d, straps_sync.sig_c,
                            straps_sync.sig_b, straps_sync.sig_a};
    end
    else
    begin
      cfg_dflt.mgmt_addr = {3'h0, straps_sync.addr_high, straps_sync.addr_low};
      cfg_dflt.power_save = 1'b1;
      cfg_dflt.rx_dly = {straps_sync.sig_a, straps_sync.sig_b, 1'b0};
      cfg_dflt.tx_dly = {straps_sync.sig_a, straps_sync.sig_b, 1'b0};
      if (straps_sync.sig_c)
      begin
        cfg_dflt.aneg_en = 1'b0;
        cfg_dflt.duplex = 1'b0;
        cfg_dflt.speed_lsb = ~straps_sync.sig_d;
      end
      if (straps_sync.sig_e)
      begin
        cfg_dflt.mac_if = SML_MAC_RMII;
      end
      else
      begin
        cfg_dflt.mac_if = straps_sync.mac_type ? SML_MAC_MII : SML_MAC_RGMII;
      end
    end
  end

  // ==========================================================================
  // APB decode
  assign acc_phase = apb_req.psel & apb_req.penable;
  assign wr_phase = acc_phase & apb_req.pwrite & pready_q;
  assign addr = apb_req.paddr;
  assign wdata = apb_req.pwdata;

  function automatic logic [31:0] read_word(input logic [7:0] a, input sml_cfg_s c,
                                            input sml_straps_s s, input logic ld,
                                            output logic hit);
    logic [31:0] w;
    w = '0;
    hit = 1'b1;
    case (a)
      SML_OFF_STRAPS:
      begin
        w[$bits(sml_straps_s)-1:0] = s;
        w[SML_BIT_LOADED] = ld;
      end
      SML_OFF_AUXCLK:
      begin
        w[SML_BIT_AUX_EN] = c.aux_en;
        w[SML_BIT_AUX_FRQ +: 2] = c.aux_freq;
      end
      SML_OFF_LINK:
      begin
        w[SML_BIT_SPD_LSB] = c.speed_lsb;
        w[SML_BIT_ANEG] = c.aneg_en;
        w[SML_BIT_DUPLEX] = c.duplex;
        w[SML_BIT_SPD_MSB] = c.speed_msb;
      end
      SML_OFF_MACIF: w[SML_BIT_MACIF +: 2] = c.mac_if;
      SML_OFF_DELAY:
      begin
        w[SML_BIT_RX_DLY +: 3] = c.rx_dly;
        w[SML_BIT_TX_DLY +: 3] = c.tx_dly;
      end
      SML_OFF_POWER: w[SML_BIT_PWR] = c.power_save;
      SML_OFF_XOVER: w[SML_BIT_XOVER +: 2] = c.xover;
      SML_OFF_ADDR:
      begin
        w[4:0] = c.mgmt_addr;
        w[SML_BIT_UNMGD] = c.unmanaged;
      end
      default: hit = 1'b0;
    endcase
    return w;
  endfunction

  always_comb
  begin
    rdata_d = read_word(addr, cfg_q, straps_q, loaded_q, hit_d);
  end

  // ==========================================================================
  // APB answer: one wait state, then pready for one cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q <= 1'b0;
      prdata_q <= '0;
      pslverr_q <= 1'b0;
    end
    else
    begin
      pready_q <= acc_phase & ~pready_q;
      if (acc_phase & ~pready_q)
      begin
        prdata_q <= apb_req.pwrite ? 32'h0000_0000 : rdata_d;
        pslverr_q <= ~hit_d;
      end
      else
      begin
        prdata_q <= '0;
        pslverr_q <= 1'b0;
      end
    end
  end

  assign apb_rsp.prdata = prdata_q;
  assign apb_rsp.pready = pready_q;
  assign apb_rsp.pslverr = pslverr_q;

  // ==========================================================================
  // Configuration registers
  // Writes land on the edge that completes the transfer. A reload at chip reset
  // release wins over a write in the same cycle; the straps are the newer truth.
  always_comb
  begin
    cfg_d = cfg_q;
    if (wr_phase)
    begin
      case (addr)
        SML_OFF_AUXCLK:
        begin
          cfg_d.aux_en = wdata[SML_BIT_AUX_EN];
          if (wdata[SML_BIT_AUX_FRQ +: 2] != 2'h3)
          begin
            cfg_d.aux_freq = wdata[SML_BIT_AUX_FRQ +: 2];
          end
        end
        SML_OFF_LINK:
        begin
          cfg_d.speed_lsb = wdata[SML_BIT_SPD_LSB];
          cfg_d.aneg_en = wdata[SML_BIT_ANEG];
          cfg_d.duplex = wdata[SML_BIT_DUPLEX];
          cfg_d.speed_msb = wdata[SML_BIT_SPD_MSB];
        end
        SML_OFF_MACIF: cfg_d.mac_if = wdata[SML_BIT_MACIF +: 2];
        SML_OFF_DELAY:
        begin
          cfg_d.rx_dly = wdata[SML_BIT_RX_DLY +: 3];
          cfg_d.tx_dly = wdata[SML_BIT_TX_DLY +: 3];
        end
        SML_OFF_POWER: cfg_d.power_save = wdata[SML_BIT_PWR];
        SML_OFF_XOVER: cfg_d.xover = wdata[SML_BIT_XOVER +: 2];
        default: cfg_d = cfg_q;
      endcase
    end
    if (release_pulse)
    begin
      cfg_d = cfg_dflt;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg_q <= '0;
      cfg_q.mgmt_addr <= SML_ADDR_RST;
      cfg_q.rx_dly <= SML_DLY_RST;
      cfg_q.tx_dly <= SML_DLY_RST;
    end
    else
    begin
      cfg_q <= cfg_d;
    end
  end

  assign cfg = cfg_q;

  // ==========================================================================
  // Auxiliary clock pin
  // While the chip is in reset the pin is an input; afterwards it is driven, low when off.
  sml_aux_clk u_aux_clk (
    .pclk(pclk),
    .presetn(presetn),
    .enable(cfg_q.aux_en & loaded_q),
    .freq(cfg_q.aux_freq),
    .clk_o(aux_clk)
  );

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      aux_clock_output_o <= 1'b0;
      aux_clock_output_oe_n <= 1'b1;
    end
    else
    begin
      aux_clock_output_o <= aux_clk & loaded_q;
      aux_clock_output_oe_n <= ~loaded_q;
    end
  end

endmodule

// File: test/sml_strap_board.sv
// Board model of the strap resistors on the far side of the strap pins.
// Assumes strap_hold from the device marks when the pins are inputs.
`timescale 1ns/100ps
module sml_strap_board (
  // Clock
  input wire logic pclk,
  // Device side
  input wire logic strap_hold,
  input wire sml_pkg::sml_straps_s level,
  output sml_pkg::sml_straps_s pins
);
  import sml_pkg::*;
  // ==========================================================================
  // Pin levels
  // After capture the pins serve other functions, so they move every cycle.
  // A design that samples late sees garbage rather than a lucky stale value.
  initial pins = '0;
  always @(posedge pclk)
  begin
    if (strap_hold)
    begin
      pins <= level;
    end
    else
    begin
      pins <= ~pins;
    end
  end
endmodule

// File: test/sml_top_assertions.sv
// Checker for the strap mode latch: timing of the pins, the bus and the configuration.
// Assumes it is bound to sml_top and sees only that module's ports.
`timescale 1ns/100ps
module sml_top_assertions (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bus
  input wire sml_pkg::sml_apb_req_s apb_req,
  input wire sml_pkg::sml_apb_rsp_s apb_rsp,
  // Pins and configuration
  input wire logic chip_reset_low,
  input wire logic strap_hold,
  input wire logic aux_clock_output_o,
  input wire logic aux_clock_output_oe_n,
  input wire sml_pkg::sml_cfg_s cfg
);
  import sml_pkg::*;
  // ==========================================================================
  // Properties
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic f25;
  logic f50;
  assign f25 = cfg.aux_en && cfg.aux_freq == SML_FRQ_25;
  assign f50 = cfg.aux_en && cfg.aux_freq == SML_FRQ_50;
  chk_hold_chip: assert property (!chip_reset_low [*6] |-> strap_hold)
    else $error("strap hold low in chip reset");
  chk_pin_quiet: assert property (!chip_reset_low [*6] |-> aux_clock_output_oe_n)
    else $error("aux pin driven in chip reset");
  chk_aux_off: assert property (!cfg.aux_en [*4] |-> !aux_clock_output_o)
    else $error("aux pin not low while disabled");
  // The enable gate or a chip reset can cut a period short, so only settled periods are timed.
  chk_rate_25: assert property (
    $rose(aux_clock_output_o) && f25 && $past(f25, 9) && !$past(aux_clock_output_oe_n, 9)
    |=> (!f25 || !$rose(aux_clock_output_o)) [*7]
    ##1 (!f25 || aux_clock_output_oe_n || $rose(aux_clock_output_o)))
    else $error("aux period not 8 cycles");
  chk_rate_50: assert property (
    $rose(aux_clock_output_o) && f50 && $past(f50, 9) && !$past(aux_clock_output_oe_n, 9)
    |=> (!f50 || !$rose(aux_clock_output_o)) [*3]
    ##1 (!f50 || aux_clock_output_oe_n || $rose(aux_clock_output_o)))
    else $error("aux period not 4 cycles");
  chk_ready_wait: assert property (apb_req.psel && apb_req.penable && !$past(apb_req.penable)
    |-> !apb_rsp.pready ##1 apb_rsp.pready)
    else $error("pready not one cycle after penable");
  chk_ready_pulse: assert property (apb_rsp.pready |=> !apb_rsp.pready)
    else $error("pready longer than one cycle");
  chk_err_map: assert property (apb_rsp.pready
    |-> apb_rsp.pslverr == (apb_req.paddr > SML_OFF_ADDR || apb_req.paddr[1:0] != 2'h0))
    else $error("pslverr wrong for address");
  chk_cfg_write: assert property ($changed(cfg) |-> $past(strap_hold)
    || $past(apb_rsp.pready) && $past(apb_req.pwrite))
    else $error("configuration changed without cause");
  cov_reload: cover property ($fell(strap_hold));
  cov_error: cover property (apb_rsp.pready && apb_rsp.pslverr);
  cov_write: cover property (apb_rsp.pready && apb_req.pwrite);
  cov_clock: cover property (f50 && $rose(aux_clock_output_o));
endmodule

bind sml_top sml_top_assertions u_chk (.pclk, .presetn, .apb_req, .apb_rsp, .chip_reset_low,
  .strap_hold, .aux_clock_output_o, .aux_clock_output_oe_n, .cfg);

// File: test/testbench.sv
// Self-checking bench for the strap mode latch: capture, registers and aux clock.
// Assumes the board model drives the straps and the checker is bound to sml_top.
`timescale 1ns/100ps
module testbench;
  import sml_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic chip_reset_low = 1'b0;
  sml_apb_req_s req = '0;
  sml_apb_rsp_s rsp;
  sml_straps_s level = '0;
  sml_straps_s pins;
  sml_cfg_s cfg;
  logic strap_hold;
  logic aux_o;
  logic aux_oe_n;
  logic [31:0] rd;
  logic err;
  int num_errors = 0;
  int compares = 0;

  always #2.5 pclk = ~pclk;

  sml_top u_dut (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
    .chip_reset_low(chip_reset_low), .strap_pins(pins), .strap_hold(strap_hold),
    .aux_clock_output_o(aux_o), .aux_clock_output_oe_n(aux_oe_n), .cfg(cfg));
  sml_strap_board u_board (.pclk(pclk), .strap_hold(strap_hold), .level(level), .pins(pins));

  // ==========================================================================
  // Helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    req.penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (rsp.pready !== 1'b1 && n < 20);
    chk(32'(n < 20), 32'h1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
  endtask

  task automatic reload(input sml_straps_s s);
    int n;
    n = 0;
    @(posedge pclk);
    chip_reset_low <= 1'b0;
    level <= s;
    repeat (10) @(posedge pclk);
    chip_reset_low <= 1'b1;
    while (strap_hold !== 1'b0 && n < 20)
    begin
      @(posedge pclk);
      n++;
    end
    repeat (3) @(posedge pclk);
    chk(32'({strap_hold, aux_oe_n}), 32'h0);
  endtask

  function automatic sml_cfg_s exp_cfg(input sml_straps_s s);
    sml_cfg_s c;
    c = '0;
    c.unmanaged = s.mgmt_sel;
    c.aux_en = s.aux_en;
    c.aux_freq = {s.freq_high, s.freq_low};
    c.mac_if = s.mac_type ? SML_MAC_MII : SML_MAC_RGMII;
    c.aneg_en = 1'b1;
    c.speed_lsb = 1'b1;
    c.duplex = 1'b1;
    c.mgmt_addr = {s.sig_e, s.sig_d, s.sig_c, s.sig_b, s.sig_a};
    if (s.mgmt_sel)
    begin
      c.mgmt_addr = {3'h0, s.addr_high, s.addr_low};
      c.power_save = 1'b1;
      c.rx_dly = {s.sig_a, s.sig_b, 1'b0};
      c.tx_dly = c.rx_dly;
      c.aneg_en = !s.sig_c;
      c.duplex = !s.sig_c;
      c.speed_lsb = !(s.sig_c && s.sig_d);
      if (s.sig_e)
      begin
        c.mac_if = SML_MAC_RMII;
      end
    end
    return c;
  endfunction

  // ==========================================================================
  // Scenarios
  task automatic t_straps();
    sml_straps_s tbl [6];
    sml_cfg_s c;
    tbl = '{12'hAD8, 12'h126, 12'hD55, 12'h6AC, 12'hFF2, 12'hC20};
    foreach (tbl[i])
    begin
      reload(tbl[i]);
      c = exp_cfg(tbl[i]);
      chk(32'(cfg), 32'(c));
      apb(1'b0, SML_OFF_STRAPS, '0);
      chk(rd, {1'b1, 19'h0, tbl[i]});
      apb(1'b0, SML_OFF_ADDR, '0);
      chk(rd, {26'h0, tbl[i].mgmt_sel, c.mgmt_addr});
      apb(1'b0, SML_OFF_DELAY, '0);
      chk(rd, {25'h0, c.rx_dly, 1'b0, c.tx_dly});
      apb(1'b0, SML_OFF_POWER, '0);
      chk(rd, {25'h0, c.power_save, 6'h00});
    end
  endtask

  task automatic t_aux();
    logic [31:0] wv [5] = '{32'h8000, 32'hA000, 32'hC000, 32'h6000, 32'h2000};
    logic [31:0] rv [5] = '{32'h8000, 32'hA000, 32'hC000, 32'h4000, 32'h2000};
    int ev [5] = '{4, 8, -1, 0, 0};
    int n;
    logic prev;
    foreach (wv[i])
    begin
      apb(1'b1, SML_OFF_AUXCLK, wv[i]);
      apb(1'b0, SML_OFF_AUXCLK, '0);
      chk(rd, rv[i]);
      repeat (8) @(posedge pclk);
      n = 0;
      prev = aux_o;
      repeat (32)
      begin
        @(posedge pclk);
        n += int'(aux_o === 1'b1 && prev === 1'b0);
        prev = aux_o;
      end
      if (ev[i] >= 0)
      begin
        chk(32'(n), 32'(ev[i]));
      end
    end
  endtask

  task automatic t_persist();
    apb(1'b1, SML_OFF_LINK, 32'h40);
    repeat (40) @(posedge pclk);
    apb(1'b0, SML_OFF_LINK, '0);
    chk(rd, 32'h40);
    chk(32'({cfg.aneg_en, cfg.speed_msb}), 32'h1);
    // A write to a read-only place is dropped without an error.
    apb(1'b1, SML_OFF_STRAPS, '1);
    chk(32'(err), 32'h0);
    apb(1'b0, 8'h24, '0);
    chk({rd[30:0], err}, 32'h1);
    apb(1'b0, SML_OFF_STRAPS, '0);
    chk(rd, {1'b1, 19'h0, 12'hC20});
    reload(12'h126);
    chk(32'(cfg), 32'(exp_cfg(12'h126)));
  endtask

  // ==========================================================================
  // Run control
  task automatic print_verdict();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
    begin
      $display("*** PASS ***");
    end
    else
    begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_straps();
    t_aux();
    t_persist();
    print_verdict();
  end

  initial
  begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    print_verdict();
  end
endmodule
